/* odf_fault_diag.sv */
// eight-channel fault diagnosis, protection and serial fault readout
`timescale 1ns/1ps
`include "odf_cfg.svh"
module odf_fault_diag (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// serial link
	input  wire logic        chip_select_n_i,
	input  wire logic        serial_clock_i,
	input  wire logic        serial_command_in_i,
	output logic             serial_data_o,
	output logic             serial_data_oe_n_o,
	// power and variant
	input  wire logic        supply_ok_i,
	input  wire logic        variant_sel_i,
	// drive
	input  wire logic [2:0]  parallel_drive_inputs_i,
	output logic [7:0]       driver_channels_o,
	// analog comparators
	input  wire logic [7:0]  over_temp_i,
	input  wire logic [7:0]  over_current_i,
	input  wire logic [7:0]  drain_mid_i,
	input  wire logic [7:0]  drain_low_i,
	// fault word view
	output logic [15:0]      channel_fault_word_o
);
	odf_pkg::odf_state_t q_ff;
	odf_pkg::odf_state_t nxt_q;
	odf_pkg::odf_pins_t  pins;
	logic                cs_fall;
	logic                cs_rise;
	logic                sck_rise;
	logic                sck_fall;
	logic                frame_ok;

	assign pins = '{cs: chip_select_n_i, sck: serial_clock_i, di: serial_command_in_i, por: supply_ok_i,
		variant: variant_sel_i, par: parallel_drive_inputs_i, hot: over_temp_i, overcurrent_code: over_current_i,
		mid: drain_mid_i, low: drain_low_i};

	always_comb begin
		logic [15:0] smp;
		logic [1:0]  code;
		logic [1:0]  cond;
		logic        par;
		logic        par_rise;
		logic        dbl_on;
		smp      = `ODF_FAULT_CLR;
		code     = `ODF_CODE_NONE;
		cond     = `ODF_CODE_NONE;
		par      = 1'b0;
		par_rise = 1'b0;
		dbl_on   = 1'b0;
		nxt_q    = q_ff;
		// only second-stage and delayed (sd) samples are read; first stage feeds nothing else
		nxt_q.s1 = pins;
		nxt_q.s2 = q_ff.s1;
		nxt_q.sd = q_ff.s2;
		cs_fall  = !q_ff.s2.cs && q_ff.sd.cs;
		cs_rise  = q_ff.s2.cs && !q_ff.sd.cs;
		sck_rise = q_ff.s2.sck && !q_ff.sd.sck && !q_ff.s2.cs;
		sck_fall = !q_ff.s2.sck && q_ff.sd.sck && !q_ff.s2.cs;
		frame_ok = cs_rise && q_ff.first_done && (q_ff.bit_cnt == `ODF_BITS_ZERO)
			&& (q_ff.first_word[`ODF_KEY_MSB:`ODF_KEY_LSB] == `ODF_KEY);

		// power-on filter
		if (!q_ff.s2.por) begin
			nxt_q.por_cnt  = '0;
			nxt_q.por_done = 1'b0;
		end else if (!q_ff.por_done) begin
			nxt_q.por_cnt = q_ff.por_cnt + 12'h001;
			if (q_ff.por_cnt == 12'(`ODF_POR_CYC - 1)) begin
				nxt_q.por_done = 1'b1;
			end
		end

		// serial receive, LSB first
		if (sck_rise) begin
			nxt_q.rx      = {q_ff.s2.di, q_ff.rx[15:1]};
			nxt_q.bit_cnt = q_ff.bit_cnt + 4'h1;
			if (q_ff.bit_cnt == `ODF_BITS_LAST && !q_ff.first_done) begin
				nxt_q.first_done = 1'b1;
				nxt_q.first_word = {q_ff.s2.di, q_ff.rx[15:1]};
			end
		end
		// after sixteen fault bits, received bits wrap around to the output
		if (sck_fall) begin
			nxt_q.sdo = q_ff.tx[1];
			nxt_q.tx  = {q_ff.rx[15], q_ff.tx[15:1]};
		end

		// select rise: apply command, clear faults
		if (cs_rise) begin
			nxt_q.oe_n      = 1'b1;
			nxt_q.prev_zero = `ODF_CHAN_NONE;
			if (frame_ok) begin
				nxt_q.therm_rep = 1'b0;
				case (q_ff.first_word[`ODF_MODE_MSB:`ODF_MODE_LSB])
					`ODF_MODE_OUT: begin
						nxt_q.cmd_out   = q_ff.first_word[`ODF_CHAN_MSB:0];
						nxt_q.prev_zero = ~q_ff.first_word[`ODF_CHAN_MSB:0];
					end
					`ODF_MODE_DIAG: nxt_q.diag_latch = q_ff.first_word[`ODF_CHAN_MSB:0];
					`ODF_MODE_PROT: nxt_q.lin_lim    = q_ff.first_word[`ODF_CHAN_MSB:0];
					default: nxt_q.cmd_out = q_ff.cmd_out;
				endcase
				for (int c = 0; c < `ODF_CH_COUNT; c++) begin
					if (!q_ff.s2.variant || q_ff.fault[2*c +: 2] != `ODF_CODE_OVC) begin
						nxt_q.fault[2*c +: 2] = `ODF_CODE_NONE;
					end
				end
			end
		end

		// per-channel protection and diagnosis
		for (int i = 0; i < `ODF_CH_COUNT; i++) begin
			// clamped index keeps the unrolled channels without a parallel input in range
			par      = (i >= `ODF_PAR_FIRST) && q_ff.s2.par[(i >= `ODF_PAR_FIRST) ? i - `ODF_PAR_FIRST : 0];
			par_rise = par && !q_ff.sd.par[(i >= `ODF_PAR_FIRST) ? i - `ODF_PAR_FIRST : 0];
			dbl_on   = frame_ok && q_ff.prev_zero[i] && nxt_q.cmd_out[i]
				&& (q_ff.first_word[`ODF_MODE_MSB:`ODF_MODE_LSB] == `ODF_MODE_OUT);
			code     = nxt_q.fault[2*i +: 2];

			// thermal: filter, then cycle off and retry
			if (!(nxt_q.cmd_out[i] || par)) begin
				nxt_q.th_off[i] = 1'b0;
				nxt_q.th_cnt[i] = '0;
			end else if (!q_ff.th_off[i]) begin
				nxt_q.th_cnt[i] = q_ff.s2.hot[i] ? q_ff.th_cnt[i] + 12'h001 : 12'h000;
				if (q_ff.s2.hot[i] && q_ff.th_cnt[i] == 12'(`ODF_THERM_CYC - 1)) begin
					nxt_q.th_off[i] = 1'b1;
					nxt_q.th_cnt[i] = '0;
				end
			end else begin
				nxt_q.th_cnt[i] = q_ff.th_cnt[i] + 12'h001;
				if (q_ff.th_cnt[i] == 12'(`ODF_TCYC_CYC - 1)) begin
					nxt_q.th_off[i] = 1'b0;
					nxt_q.th_cnt[i] = '0;
				end
			end

			// restart paths for an overcurrent stop
			if (q_ff.oc_stop[i]) begin
				nxt_q.res_cnt[i] = q_ff.res_cnt[i] + 12'h001;
				if (q_ff.res_cnt[i] == 12'(`ODF_TRES_CYC - 1)) begin
					nxt_q.oc_stop[i] = 1'b0;
					nxt_q.res_cnt[i] = '0;
					if (q_ff.s2.variant && code == `ODF_CODE_OVC) begin
						code = `ODF_CODE_NONE;
					end
				end
				if (dbl_on || par_rise) begin
					nxt_q.oc_stop[i] = 1'b0;
					nxt_q.res_cnt[i] = '0;
				end
			end
			if (q_ff.s2.variant && (i >= `ODF_PAR_FIRST) && !par && code == `ODF_CODE_OVC) begin
				code = `ODF_CODE_NONE;
			end

			// latch mode filter on the off-state drain level
			cond = q_ff.s2.mid[i] ? `ODF_CODE_OPEN : (q_ff.s2.low[i] ? `ODF_CODE_SHORT : `ODF_CODE_NONE);
			if (q_ff.diag_latch[i] && !q_ff.drv[i] && cond != `ODF_CODE_NONE && cond == q_ff.flt_kind[i]) begin
				nxt_q.flt_cnt[i] = q_ff.flt_cnt[i] + 12'h001;
				if (q_ff.flt_cnt[i] == 12'(`ODF_TFILT_CYC - 1) && code != `ODF_CODE_OVC) begin
					code = cond;
				end
			end else begin
				nxt_q.flt_cnt[i] = '0;
			end
			nxt_q.flt_kind[i] = cond;

			// no-latch sample at select fall: present condition only
			if (cs_fall && !q_ff.diag_latch[i] && code != `ODF_CODE_OVC) begin
				code = q_ff.drv[i] ? `ODF_CODE_NONE : cond;
			end

			// overcurrent filter; written after clears so the set wins
			if (!q_ff.lin_lim[i] && q_ff.drv[i] && q_ff.s2.overcurrent_code[i]) begin
				nxt_q.oc_cnt[i] = q_ff.oc_cnt[i] + 12'h001;
				if (q_ff.oc_cnt[i] == 12'(`ODF_TDEL_CYC - 1)) begin
					nxt_q.oc_stop[i] = 1'b1;
					nxt_q.oc_cnt[i]  = '0;
					nxt_q.res_cnt[i] = '0;
					code             = `ODF_CODE_OVC;
				end
			end else begin
				nxt_q.oc_cnt[i] = '0;
			end
			nxt_q.fault[2*i +: 2] = code;
		end

		// select fall: thermal override and readout load
		smp = nxt_q.fault;
		if (cs_fall) begin
			if (|q_ff.th_off) begin
				nxt_q.therm_rep = 1'b1;
			end
			nxt_q.tx         = nxt_q.therm_rep ? `ODF_FAULT_ALL : smp;
			nxt_q.sdo        = nxt_q.therm_rep ? 1'b1 : smp[0];
			nxt_q.oe_n       = 1'b0;
			nxt_q.bit_cnt    = `ODF_BITS_ZERO;
			nxt_q.first_done = 1'b0;
		end

		// power-on clear holds commands, modes, faults and protection states cleared and the drivers off
		if (!nxt_q.por_done) begin
			nxt_q.cmd_out    = `ODF_CHAN_NONE;
			nxt_q.diag_latch = `ODF_CHAN_NONE;
			nxt_q.lin_lim    = `ODF_CHAN_NONE;
			nxt_q.fault      = `ODF_FAULT_CLR;
			nxt_q.therm_rep  = 1'b0;
			nxt_q.oc_stop    = `ODF_CHAN_NONE;
			nxt_q.th_off     = `ODF_CHAN_NONE;
		end
		for (int k = 0; k < `ODF_CH_COUNT; k++) begin
			par = (k >= `ODF_PAR_FIRST) && q_ff.s2.par[(k >= `ODF_PAR_FIRST) ? k - `ODF_PAR_FIRST : 0];
			nxt_q.drv[k] = nxt_q.por_done && (nxt_q.cmd_out[k] || par)
				&& !nxt_q.oc_stop[k] && !nxt_q.th_off[k];
		end
		nxt_q.word = nxt_q.therm_rep ? `ODF_FAULT_ALL : nxt_q.fault;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			q_ff        <= '0;
			q_ff.oe_n   <= 1'b1;
			q_ff.s1.cs  <= 1'b1;
			q_ff.s2.cs  <= 1'b1;
			q_ff.sd.cs  <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign serial_data_o        = q_ff.sdo;
	assign serial_data_oe_n_o   = q_ff.oe_n;
	assign driver_channels_o    = q_ff.drv;
	assign channel_fault_word_o = q_ff.word;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	por_hold_off_a: assert property (!q_ff.s2.por |=> driver_channels_o == `ODF_CHAN_NONE)
		else $error("driver on before power-on clear");
	por_filter_a: assert property (!q_ff.s2.por ##1 q_ff.s2.por [*8] |-> !q_ff.por_done)
		else $error("power-on clear released too early");
	therm_all_ones_a: assert property (cs_fall && |q_ff.th_off |=> q_ff.tx == `ODF_FAULT_ALL)
		else $error("thermal shutdown not reported as all ones");
	therm_clear_a: assert property (frame_ok |=> !q_ff.therm_rep)
		else $error("thermal report kept after valid frame");
	oc_trip_a: assert property ($rose(q_ff.oc_stop[0]) |-> q_ff.fault[1:0] == `ODF_CODE_OVC
		&& !driver_channels_o[0])
		else $error("overcurrent stop without code or output still on");
	oc_keep_code_a: assert property (q_ff.fault[1:0] == `ODF_CODE_OVC && !q_ff.s2.variant && !cs_rise
		&& q_ff.s2.por && q_ff.por_done |=> q_ff.fault[1:0] == `ODF_CODE_OVC)
		else $error("overcurrent code overwritten");
	lin_no_ovc_a: assert property (q_ff.lin_lim[0] && !cs_rise && q_ff.fault[1:0] != `ODF_CODE_OVC
		|=> q_ff.fault[1:0] != `ODF_CODE_OVC)
		else $error("overcurrent reported under linear limit");
	invalid_frame_a: assert property (cs_rise && !frame_ok && q_ff.s2.por && q_ff.por_done
		|=> $stable(q_ff.cmd_out))
		else $error("command taken from invalid frame");
	nolatch_open_a: assert property (cs_fall && !q_ff.diag_latch[0] && !q_ff.drv[0] && q_ff.s2.mid[0]
		&& q_ff.fault[1:0] != `ODF_CODE_OVC && q_ff.por_done && q_ff.s2.por
		|=> q_ff.fault[1:0] == `ODF_CODE_OPEN)
		else $error("no-latch open load not sampled");
	readout_a: assert property (cs_fall |=> !serial_data_oe_n_o && serial_data_o == q_ff.tx[0])
		else $error("fault word not presented at select fall");
	sdo_shift_a: assert property (sck_fall && !cs_fall
		|=> serial_data_o == $past(q_ff.tx[1]))
		else $error("serial output did not advance on clock fall");
	oe_release_a: assert property (cs_rise
		|=> serial_data_oe_n_o)
		else $error("serial output still driven after select rise");
	frame_cmd_a: assert property (frame_ok && q_ff.s2.por && q_ff.por_done
		&& q_ff.first_word[`ODF_MODE_MSB:`ODF_MODE_LSB] == `ODF_MODE_OUT
		|=> q_ff.cmd_out == $past(q_ff.first_word[`ODF_CHAN_MSB:0]))
		else $error("valid output frame not applied");
	first_clear_a: assert property (frame_ok && !q_ff.s2.variant && !q_ff.drv[0]
		&& !q_ff.diag_latch[0] && q_ff.s2.por && q_ff.por_done
		|=> q_ff.fault[1:0] == `ODF_CODE_NONE)
		else $error("first variant code kept after valid frame");

	// overcurrent stop gating, filter expiry, restart delay and second-variant code clear
	oc_gate_off_a: assert property (q_ff.oc_stop[0]
		|-> !driver_channels_o[0])
		else $error("driver on during overcurrent stop");
	oc_filter_a: assert property (!q_ff.lin_lim[0] && q_ff.drv[0] && q_ff.s2.overcurrent_code[0]
		&& q_ff.s2.por && q_ff.por_done && q_ff.oc_cnt[0] == 12'(`ODF_TDEL_CYC - 1)
		|=> q_ff.oc_stop[0] && q_ff.fault[1:0] == `ODF_CODE_OVC)
		else $error("overcurrent filter expiry missed");
	restart_delay_a: assert property (q_ff.oc_stop[0]
		&& q_ff.res_cnt[0] == 12'(`ODF_TRES_CYC - 1) |=> !q_ff.oc_stop[0])
		else $error("restart delay expiry did not restart");
	var2_clear_a: assert property (q_ff.s2.variant && !q_ff.s2.par[0] && !q_ff.drv[5]
		&& q_ff.fault[11:10] == `ODF_CODE_OVC && q_ff.s2.por && q_ff.por_done
		|=> q_ff.fault[11:10] != `ODF_CODE_OVC)
		else $error("overcurrent code kept while parallel input low");

	// thermal cut-off, retry and report
	therm_gate_off_a: assert property (q_ff.th_off[2]
		|-> !driver_channels_o[2])
		else $error("driver on during thermal cut-off");
	therm_retry_a: assert property (q_ff.th_off[2]
		&& q_ff.th_cnt[2] == 12'(`ODF_TCYC_CYC - 1) |=> !q_ff.th_off[2])
		else $error("thermal cut-off did not retry");
	therm_word_a: assert property (q_ff.therm_rep
		|-> channel_fault_word_o == `ODF_FAULT_ALL)
		else $error("thermal report not shown as all ones");

	// latch filter expiry writes the held condition
	latch_short_a: assert property (q_ff.diag_latch[0] && !q_ff.drv[0] && q_ff.s2.low[0]
		&& !q_ff.s2.mid[0] && q_ff.flt_kind[0] == `ODF_CODE_SHORT && q_ff.s2.por && q_ff.por_done
		&& q_ff.flt_cnt[0] == 12'(`ODF_TFILT_CYC - 1) && q_ff.fault[1:0] != `ODF_CODE_OVC
		|=> q_ff.fault[1:0] == `ODF_CODE_SHORT)
		else $error("latched short not recorded");
	latch_open_a: assert property (q_ff.diag_latch[0] && !q_ff.drv[0] && q_ff.s2.mid[0]
		&& q_ff.flt_kind[0] == `ODF_CODE_OPEN && q_ff.s2.por && q_ff.por_done
		&& q_ff.flt_cnt[0] == 12'(`ODF_TFILT_CYC - 1) && q_ff.fault[1:0] != `ODF_CODE_OVC
		|=> q_ff.fault[1:0] == `ODF_CODE_OPEN)
		else $error("latched open load not recorded");

	oc_trip_c: cover property ($rose(q_ff.oc_stop[0]));
	therm_rep_c: cover property ($rose(q_ff.therm_rep));
	valid_frame_c: cover property (frame_ok);
	latch_set_c: cover property (q_ff.diag_latch[0] && q_ff.flt_cnt[0] == 12'(`ODF_TFILT_CYC - 1));
	restart_c: cover property ($fell(q_ff.oc_stop[0]));
endmodule // odf_fault_diag

/* odf_cfg.svh */
// constants for the octal driver fault diagnostics block
`ifndef ODF_CFG_SVH
`define ODF_CFG_SVH
`define ODF_CLK_MHZ      20
`define ODF_POR_US       5
`define ODF_THERM_US     5
`define ODF_TDEL_US      10
`define ODF_TFILT_US     20
`define ODF_TRES_US      100
`define ODF_TCYC_US      50
`define ODF_POR_CYC      (`ODF_POR_US * `ODF_CLK_MHZ)
`define ODF_THERM_CYC    (`ODF_THERM_US * `ODF_CLK_MHZ)
`define ODF_TDEL_CYC     (`ODF_TDEL_US * `ODF_CLK_MHZ)
`define ODF_TFILT_CYC    (`ODF_TFILT_US * `ODF_CLK_MHZ)
`define ODF_TRES_CYC     (`ODF_TRES_US * `ODF_CLK_MHZ)
`define ODF_TCYC_CYC     (`ODF_TCYC_US * `ODF_CLK_MHZ)
`define ODF_KEY_MSB      15
`define ODF_KEY_LSB      12
`define ODF_MODE_MSB     11
`define ODF_MODE_LSB     8
`define ODF_CHAN_MSB     7
`define ODF_KEY          4'hA
`define ODF_MODE_OUT     4'hC
`define ODF_MODE_DIAG    4'h3
`define ODF_MODE_PROT    4'hA
`define ODF_CODE_NONE    2'h0
`define ODF_CODE_OPEN    2'h1
`define ODF_CODE_SHORT   2'h2
`define ODF_CODE_OVC     2'h3
`define ODF_FAULT_ALL    16'hFFFF
`define ODF_FAULT_CLR    16'h0000
`define ODF_CHAN_NONE    8'h00
`define ODF_BITS_LAST    4'hF
`define ODF_BITS_ZERO    4'h0
`define ODF_PAR_FIRST    5
`define ODF_CH_COUNT     8
`endif

/* odf_pkg.sv */
// types for the octal driver fault diagnostics block
package odf_pkg;
	typedef logic [11:0] odf_cnt_t;

	typedef struct packed {
		logic       cs;
		logic       sck;
		logic       di;
		logic       por;
		logic       variant;
		logic [2:0] par;
		logic [7:0] hot;
		logic [7:0] overcurrent_code;
		logic [7:0] mid;
		logic [7:0] low;
	} odf_pins_t;

	typedef struct packed {
		odf_pins_t           s1;
		odf_pins_t           s2;
		odf_pins_t           sd;
		odf_cnt_t            por_cnt;
		logic                por_done;
		logic [7:0]          cmd_out;
		logic [7:0]          diag_latch;
		logic [7:0]          lin_lim;
		logic [7:0]          drv;
		logic [7:0]          oc_stop;
		logic [7:0]          th_off;
		logic [7:0]          prev_zero;
		logic [15:0]         fault;
		logic [15:0]         word;
		logic [15:0]         rx;
		logic [15:0]         tx;
		logic [15:0]         first_word;
		logic [3:0]          bit_cnt;
		logic                first_done;
		logic                therm_rep;
		logic                sdo;
		logic                oe_n;
		logic [7:0][11:0]    oc_cnt;
		logic [7:0][11:0]    res_cnt;
		logic [7:0][11:0]    th_cnt;
		logic [7:0][11:0]    flt_cnt;
		logic [7:0][1:0]     flt_kind;
	} odf_state_t;
endpackage

/* odf_spi_host.sv */
// serial bus controller model that frames commands into the fault block
`timescale 1ns/1ps
module odf_spi_host (
	// clock
	input  wire logic        clk_i,
	// bench commands
	input  wire logic        start_i,
	input  wire logic [15:0] word_i,
	input  wire logic [4:0]  nbits_i,
	output logic             busy_o,
	output logic [15:0]      rx_o,
	// serial link
	output logic             cs_n_o,
	output logic             sck_o,
	output logic             di_o,
	input  wire logic        do_i
);
	int i;
	// four clocks a phase gives the 400 ns link clock
	task automatic half();
		repeat (4) @(posedge clk_i);
	endtask
	initial begin
		busy_o = 1'b0;
		sck_o = 1'b0;
		rx_o = 16'h0000;
		cs_n_o = 1'b1;
		di_o = 1'b1;
		forever begin
			@(posedge clk_i);
			if (start_i) begin
				busy_o <= 1'b1;
				cs_n_o <= 1'b0;
				half();
				half();
				// link clock runs only inside the frame
				for (i = 0; i < nbits_i; i++) begin
					di_o <= word_i[i[3:0]];
					half();
					sck_o <= 1'b1;
					half();
					// out bit is stable from the last fall until just after this one
					if (i < 16)
						rx_o[i] = do_i;
					sck_o <= 1'b0;
				end
				// data line is driven back high once the bits are sent
				di_o <= 1'b1;
				half();
				cs_n_o <= 1'b1;
				half();
				half();
				busy_o <= 1'b0;
			end
		end
	end
endmodule // odf_spi_host

/* test_odf_fault_diag.sv */
// self-checking bench for the octal driver fault diagnostics block
`timescale 1ns/1ps
`include "odf_cfg.svh"
module test_odf_fault_diag;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        supply_ok = 1'b0;
	logic        variant = 1'b0;
	logic        start = 1'b0;
	logic [2:0]  par = 3'h7;
	logic [7:0]  ot = 8'h00;
	logic [7:0]  oc = 8'h00;
	logic [7:0]  mid = 8'h00;
	logic [7:0]  low = 8'h00;
	logic [15:0] word = 16'h0000;
	logic [4:0]  nbits = 5'h10;
	logic [15:0] rx;
	logic [15:0] fw;
	logic [7:0]  drv;
	logic        cs_n, sck, di, sdo, oe_n, busy;
	wire         do_pin = oe_n ? 1'bz : sdo;
	int          checked = 0;
	int          n_fail = 0;

	always #25 clk_i = ~clk_i;

	odf_fault_diag odf_fault_diag_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .chip_select_n_i(cs_n),
		.serial_clock_i(sck), .serial_command_in_i(di), .serial_data_o(sdo), .serial_data_oe_n_o(oe_n),
		.supply_ok_i(supply_ok), .variant_sel_i(variant), .parallel_drive_inputs_i(par),
		.driver_channels_o(drv), .over_temp_i(ot), .over_current_i(oc), .drain_mid_i(mid),
		.drain_low_i(low), .channel_fault_word_o(fw));
	odf_spi_host odf_spi_host_i (.clk_i(clk_i), .start_i(start), .word_i(word), .nbits_i(nbits),
		.busy_o(busy), .rx_o(rx), .cs_n_o(cs_n), .sck_o(sck), .di_o(di), .do_i(do_pin));

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic frame(input logic [15:0] w, input logic [4:0] n);
		int k;
		@(posedge clk_i);
		word <= w;
		nbits <= n;
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		@(posedge clk_i);
		for (k = 0; k < 400 && busy !== 1'b0; k++)
			@(posedge clk_i);
	endtask
	task automatic send(input logic [3:0] mode, input logic [7:0] data);
		frame({`ODF_KEY, mode, data}, 5'h10);
	endtask
	task automatic t_por();
		cyc(30);
		chk("drv before por", {8'h00, drv}, 16'h0000);
		par <= 3'h0;
		supply_ok <= 1'b1;
		cyc(120);
		chk("word after por", fw, `ODF_FAULT_CLR);
		send(`ODF_MODE_OUT, 8'hFF);
		chk("first readout", rx, `ODF_FAULT_CLR);
		chk("data out released", {15'h0000, oe_n}, 16'h0001);
		chk("drv all on", {8'h00, drv}, 16'h00FF);
		send(`ODF_MODE_OUT, 8'h00);
	endtask
	task automatic t_nolatch();
		mid[0] <= 1'b1;
		low[1] <= 1'b1;
		send(`ODF_MODE_OUT, 8'h00);
		chk("nolatch codes", rx, 16'h0009);
		mid <= 8'h00;
		low <= 8'h00;
		send(`ODF_MODE_OUT, 8'h00);
		chk("nolatch gone", rx, 16'h0000);
	endtask
	task automatic t_latch();
		send(`ODF_MODE_DIAG, 8'h03);
		low[0] <= 1'b1;
		cyc(300);
		low[0] <= 1'b0;
		cyc(5);
		chk("short too brief", fw, 16'h0000);
		low[0] <= 1'b1;
		mid[1] <= 1'b1;
		cyc(450);
		low[0] <= 1'b0;
		mid[1] <= 1'b0;
		cyc(5);
		chk("latched codes", fw, 16'h0006);
		send(`ODF_MODE_DIAG, 8'h00);
		chk("latched readout", rx, 16'h0006);
		chk("cleared by frame", fw, 16'h0000);
	endtask
	task automatic t_ovc();
		send(`ODF_MODE_OUT, 8'h01);
		oc[0] <= 1'b1;
		cyc(190);
		chk("still on", {15'h0000, drv[0]}, 16'h0001);
		cyc(20);
		chk("tripped off", {15'h0000, drv[0]}, 16'h0000);
		chk("ovc code", fw, 16'h0003);
		oc[0] <= 1'b0;
		mid[0] <= 1'b1;
		frame({4'h5, `ODF_MODE_OUT, 8'h00}, 5'h10);
		chk("bad key readout", rx, 16'h0003);
		frame({`ODF_KEY, `ODF_MODE_OUT, 8'h00}, 5'h0F);
		chk("short frame kept", fw, 16'h0003);
		mid[0] <= 1'b0;
		send(`ODF_MODE_OUT, 8'h01);
		chk("single one no restart", {15'h0000, drv[0]}, 16'h0000);
		send(`ODF_MODE_OUT, 8'h00);
		send(`ODF_MODE_OUT, 8'h01);
		chk("double write restart", {15'h0000, drv[0]}, 16'h0001);
		oc[0] <= 1'b1;
		cyc(210);
		oc[0] <= 1'b0;
		cyc(2050);
		chk("auto restart", {15'h0000, drv[0]}, 16'h0001);
		send(`ODF_MODE_OUT, 8'h00);
	endtask
	task automatic t_lin();
		send(`ODF_MODE_PROT, 8'h01);
		send(`ODF_MODE_OUT, 8'h01);
		oc[0] <= 1'b1;
		cyc(250);
		chk("limit stays on", {15'h0000, drv[0]}, 16'h0001);
		chk("limit no code", fw, 16'h0000);
		oc[0] <= 1'b0;
		send(`ODF_MODE_OUT, 8'h00);
		send(`ODF_MODE_PROT, 8'h00);
	endtask
	task automatic t_therm();
		send(`ODF_MODE_OUT, 8'h04);
		ot[2] <= 1'b1;
		cyc(90);
		chk("filter holds", {15'h0000, drv[2]}, 16'h0001);
		cyc(20);
		chk("thermal off", {15'h0000, drv[2]}, 16'h0000);
		send(`ODF_MODE_OUT, 8'h04);
		chk("thermal all ones", rx, `ODF_FAULT_ALL);
		chk("thermal cleared", fw, `ODF_FAULT_CLR);
		cyc(880);
		chk("thermal retry", {15'h0000, drv[2]}, 16'h0001);
		ot[2] <= 1'b0;
		send(`ODF_MODE_OUT, 8'h00);
	endtask
	task automatic t_var2();
		variant <= 1'b1;
		par[0] <= 1'b1;
		cyc(5);
		oc[5] <= 1'b1;
		cyc(220);
		chk("ch6 tripped", {15'h0000, drv[5]}, 16'h0000);
		chk("ch6 ovc code", {14'h0000, fw[11:10]}, 16'h0003);
		oc[5] <= 1'b0;
		par[0] <= 1'b0;
		// read only after the switching transient has passed
		cyc(10);
		chk("low input clears", {14'h0000, fw[11:10]}, 16'h0000);
		par[0] <= 1'b1;
		cyc(10);
		chk("rising input restart", {15'h0000, drv[5]}, 16'h0001);
		par[0] <= 1'b0;
		variant <= 1'b0;
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		cyc(20);
		rst_n_i <= 1'b1;
		t_por();
		t_nolatch();
		t_latch();
		t_ovc();
		t_lin();
		t_therm();
		t_var2();
		give_verdict();
	end
	// whole run needs about eight thousand cycles
	initial begin
		cyc(30000);
		n_fail++;
		give_verdict();
	end
endmodule // test_odf_fault_diag
